// File: hw/dme_divider.sv
// Iterative restoring divider, one step per divisor bit
`default_nettype none
module dme_divider
  import dme_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Request
  input wire logic start_i,
  input wire logic signed_i,
  input wire logic [31:0] dividend_i,
  input wire logic [15:0] divisor_i,
  // Result
  output logic done_o,
  output logic [15:0] quot_o,
  output logic [15:0] rem_o
);
  logic [4:0] cnt;
  logic [15:0] part;
  logic [15:0] low;
  logic [15:0] dvs;
  logic neg_q;
  logic neg_r;
  logic [16:0] trial;
  logic fits;
  logic [15:0] next_part;
  logic [15:0] next_low;

  always_comb begin
    trial = {part, low[15]};
    fits = trial >= {1'b0, dvs};
    next_part = fits ? 16'(trial - {1'b0, dvs}) : trial[15:0];
    next_low = {low[14:0], fits};
  end

  // Magnitudes go through the loop, signs are fixed on the way out
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 5'h00;
      part <= 16'h0000;
      low <= 16'h0000;
      dvs <= 16'h0000;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
    end else if (start_i) begin
      cnt <= DME_DIV_CNT;
      neg_q <= signed_i & (dividend_i[31] ^ divisor_i[15]);
      neg_r <= signed_i & dividend_i[31];
      dvs <= (signed_i && divisor_i[15]) ? 16'(-divisor_i) : divisor_i;
      {part, low} <= (signed_i && dividend_i[31]) ?
                     32'(-dividend_i) : dividend_i;
    end else if (cnt != 5'h00) begin
      cnt <= 5'(cnt - 5'h01);
      part <= next_part;
      low <= next_low;
    end
  end

  // Quotient wider than 16 bits is not detected and comes out wrong, as does the remainder
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      quot_o <= 16'h0000;
      rem_o <= 16'h0000;
    end else begin
      done_o <= (cnt == 5'h01);
      if (cnt == 5'h01) begin
        quot_o <= neg_q ? 16'(-next_low) : next_low;
        rem_o <= neg_r ? 16'(-next_part) : next_part;
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/dme_engine.sv
// DSP arithmetic engine: multiplier, accumulator adder and divider
`default_nettype none
module dme_engine
  import dme_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Instruction request from the sequencer
  input wire dme_req_t req_i,
  input wire logic [15:0] x_i,
  input wire logic [15:0] y_i,
  input wire logic [39:0] shift_data_i,
  input wire logic [15:0][15:0] wreg_file_i,
  // Configuration and software flag clears
  input wire logic [15:0] core_control_reg_i,
  input wire dme_trap_en_t trap_en_i,
  input wire logic [1:0] sat_clear_i,
  // Accumulators and status
  output logic [39:0] acc_a_o,
  output logic [39:0] acc_b_o,
  output dme_status_t status_o,
  output logic arith_trap_o,
  // Sequencing and register write-back
  output logic busy_o,
  output dme_div_wr_t div_wr_o,
  output dme_mul_wr_t mul_wr_o
);
  dme_state_t state;
  logic take;
  logic dsp_take;
  logic is_dsp;
  logic div_start;
  logic div_done;
  logic [15:0] div_quot;
  logic [15:0] div_rem;
  logic [15:0] divisor;
  logic [31:0] dividend;
  logic [15:0] dvd_lo;
  logic [15:0] diff;
  logic [15:0] ma;
  logic [15:0] mb;
  logic sgn_a;
  logic sgn_b;
  logic [16:0] m17a;
  logic [16:0] m17b;
  logic signed [33:0] prod;
  logic [32:0] prod33;
  logic [39:0] prod40;
  logic [39:0] acc_src;
  logic [39:0] acc_oth;
  logic [39:0] opa;
  logic [39:0] opb;
  logic [39:0] opb_eff;
  logic sub;
  logic [39:0] sum;
  logic ov39;
  logic ov31;
  logic guard;
  logic neg_true;
  logic sat_en;
  logic super_mode;
  logic [39:0] res;
  logic sat_hit;
  logic guard_flag;
  logic cat_trap;
  logic ovf_trap;
  logic [1:0] guard_q;
  logic [1:0] sat_q;
  logic [1:0] next_guard;
  logic [1:0] next_sat;

  // One instruction at a time; a running divide refuses all others
  always_comb begin
    take = req_i.valid && (state == DME_IDLE);
    case (req_i.op)
      DME_OP_NONE, DME_OP_MUL, DME_OP_DIV: is_dsp = 1'b0;
      default: is_dsp = 1'b1;
    endcase
    dsp_take = take && is_dsp;
    div_start = take && (req_i.op == DME_OP_DIV);
  end

  // Divider operand fetch
  always_comb begin
    divisor = wreg_file_i[req_i.divisor_idx];
    dvd_lo = wreg_file_i[{req_i.dividend_idx[3:1], 1'b0}];
    if (req_i.div_long) begin
      dividend = {wreg_file_i[{req_i.dividend_idx[3:1], 1'b1}], dvd_lo};
    end else begin
      dividend = {{16{req_i.div_signed & dvd_lo[15]}}, dvd_lo};
    end
  end

  dme_divider u_divider (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(div_start),
    .signed_i(req_i.div_signed),
    .dividend_i(dividend),
    .divisor_i(divisor),
    .done_o(div_done),
    .quot_o(div_quot),
    .rem_o(div_rem)
  );

  // Operand selection for the shared multiplier
  always_comb begin
    diff = 16'(x_i - y_i);
    ma = x_i;
    mb = y_i;
    sgn_a = ~core_control_reg_i[DME_CC_SIGN];
    sgn_b = ~core_control_reg_i[DME_CC_SIGN];
    case (req_i.op)
      DME_OP_ED, DME_OP_DIFF_SQUARE_ACCUM_OP: begin
        ma = diff;
        mb = diff;
        sgn_a = 1'b1;
        sgn_b = 1'b1;
      end
      DME_OP_MUL: begin
        sgn_a = req_i.mul_x_signed;
        sgn_b = req_i.mul_y_signed;
        if (req_i.mul_byte) begin
          ma = {8'h00, x_i[7:0]};
          mb = {8'h00, y_i[7:0]};
          sgn_a = 1'b0;
          sgn_b = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  // Multiplier and scaler
  always_comb begin
    m17a = {sgn_a & ma[15], ma};
    m17b = {sgn_b & mb[15], mb};
    prod = $signed(m17a) * $signed(m17b);
    if (core_control_reg_i[DME_CC_FRAC]) begin
      prod33 = {prod[31:0], 1'b0};
    end else begin
      prod33 = prod[32:0];
    end
    prod40 = {{7{prod33[32]}}, prod33};
  end

  // Adder operand routing
  always_comb begin
    acc_src = req_i.acc_sel ? acc_b_o : acc_a_o;
    acc_oth = req_i.acc_sel ? acc_a_o : acc_b_o;
    opa = acc_src;
    opb = DME_ACC_RST;
    sub = 1'b0;
    case (req_i.op)
      DME_OP_ADD_ACC: opb = acc_oth;
      DME_OP_SUB_ACC: begin
        opb = acc_oth;
        sub = 1'b1;
      end
      DME_OP_NEG_ACC: begin
        opa = DME_ACC_RST;
        opb = acc_src;
        sub = 1'b1;
      end
      DME_OP_CLR: opa = DME_ACC_RST;
      DME_OP_MAC, DME_OP_DIFF_SQUARE_ACCUM_OP: opb = prod40;
      DME_OP_MSC: begin
        opb = prod40;
        sub = 1'b1;
      end
      DME_OP_MPY, DME_OP_ED: begin
        opa = DME_ACC_RST;
        opb = prod40;
      end
      DME_OP_NEGATED_MULTIPLY_OP: begin
        opa = DME_ACC_RST;
        opb = prod40;
        sub = 1'b1;
      end
      DME_OP_LAC: begin
        opa = DME_ACC_RST;
        opb = shift_data_i;
      end
      DME_OP_ADD_DATA: opb = shift_data_i;
      default: begin
      end
    endcase
  end

  // Adder; the carry-in doubles as an active-low borrow when subtracting
  always_comb begin
    opb_eff = sub ? ~opb : opb;
    sum = 40'(opa + opb_eff + {39'h0, sub});
    ov39 = (opa[39] == opb_eff[39]) && (sum[39] != opa[39]);
    guard = ~(&sum[39:32]) && (|sum[39:32]);
    ov31 = ov39 || (~(&sum[39:31]) && (|sum[39:31]));
    neg_true = ov39 ? ~sum[39] : sum[39];
  end

  // Saturation decision per target accumulator
  always_comb begin
    sat_en = req_i.acc_sel ? core_control_reg_i[DME_CC_ACC_B_SAT_ENABLE] :
             core_control_reg_i[DME_CC_ACC_A_SAT_ENABLE];
    super_mode = core_control_reg_i[DME_CC_SAT_MODE];
    res = sum;
    sat_hit = 1'b0;
    guard_flag = guard;
    cat_trap = 1'b0;
    if (sat_en && super_mode) begin
      if (ov39) begin
        res = neg_true ? DME_SUP_NEG : DME_SUP_POS;
        sat_hit = 1'b1;
      end
    end else if (sat_en) begin
      guard_flag = 1'b0;
      if (ov31) begin
        res = neg_true ? DME_Q31_NEG : DME_Q31_POS;
        sat_hit = 1'b1;
      end
    end else begin
      sat_hit = ov39;
      cat_trap = ov39 && trap_en_i.catastrophic_trap_en;
    end
    ovf_trap = guard_flag && (req_i.acc_sel ?
               trap_en_i.acc_b_overflow_trap_en :
               trap_en_i.acc_a_overflow_trap_en);
  end

  // Flag next values; a set in the clearing cycle wins
  always_comb begin
    next_guard = guard_q;
    next_sat = sat_q & ~sat_clear_i;
    if (dsp_take) begin
      next_guard[req_i.acc_sel] = guard_flag;
      next_sat[req_i.acc_sel] = next_sat[req_i.acc_sel]
                                | sat_hit;
    end
  end

  // Accumulators
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_a_o <= DME_ACC_RST;
      acc_b_o <= DME_ACC_RST;
    end else if (dsp_take) begin
      if (req_i.acc_sel) begin
        acc_b_o <= res;
      end else begin
        acc_a_o <= res;
      end
    end
  end

  // Status flags and trap
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      guard_q <= 2'h0;
      sat_q <= 2'h0;
      status_o <= '0;
      arith_trap_o <= 1'b0;
    end else begin
      guard_q <= next_guard;
      sat_q <= next_sat;
      status_o.acc_a_guard_overflow <= next_guard[0];
      status_o.acc_b_guard_overflow <= next_guard[1];
      status_o.acc_a_saturated <= next_sat[0];
      status_o.acc_b_saturated <= next_sat[1];
      status_o.any_guard_overflow <= |next_guard;
      status_o.any_saturated <= |next_sat;
      arith_trap_o <= dsp_take && (ovf_trap || cat_trap);
    end
  end

  // Integer multiply write-back
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mul_wr_o <= '0;
    end else begin
      mul_wr_o.valid <= take && (req_i.op == DME_OP_MUL);
      mul_wr_o.word <= ~req_i.mul_byte;
      mul_wr_o.data <= req_i.mul_byte ? {16'h0000, prod[15:0]} :
                       prod[31:0];
    end
  end

  // Divide sequencing; busy covers every step and falls on the edge that issues the result write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= DME_IDLE;
      busy_o <= 1'b0;
      div_wr_o <= '0;
    end else begin
      div_wr_o.valid <= 1'b0;
      case (state)
        DME_IDLE: begin
          if (div_start) begin
            state <= DME_DIV;
            busy_o <= 1'b1;
          end
        end
        DME_DIV: begin
          if (div_done) begin
            state <= DME_IDLE;
            busy_o <= 1'b0;
            div_wr_o.valid <= 1'b1;
            div_wr_o.quot <= div_quot;
            div_wr_o.rem <= div_rem;
          end
        end
        default: begin
          state <= DME_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_div_start;
    div_start;
  endsequence

  sequence s_div_steps;
    busy_o [*8] ##1 busy_o [*8] ##1 busy_o;
  endsequence

  property p_div_time;
    s_div_start |-> ##18 div_wr_o.valid;
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("divide result not written after 18 cycles");

  property p_div_busy;
    s_div_start |=> s_div_steps ##1 !busy_o;
  endproperty
  a_div_busy: assert property (p_div_busy)
    else $error("busy does not span the divide");

  property p_busy_stall;
    busy_o && req_i.valid |=> $stable(acc_a_o) && $stable(acc_b_o)
      && !mul_wr_o.valid;
  endproperty
  a_busy_stall: assert property (p_busy_stall)
    else $error("request taken while divider busy");

  property p_summary;
    status_o.any_guard_overflow == (status_o.acc_a_guard_overflow
      | status_o.acc_b_guard_overflow) && status_o.any_saturated ==
      (status_o.acc_a_saturated | status_o.acc_b_saturated);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bits disagree with flags");

  property p_sat_sticky;
    status_o.acc_a_saturated && !sat_clear_i[0]
      |=> status_o.acc_a_saturated;
  endproperty
  a_sat_sticky: assert property (p_sat_sticky)
    else $error("saturation flag cleared without software");

  property p_guard_trap;
    dsp_take && guard && !sat_en && (req_i.acc_sel ?
      trap_en_i.acc_b_overflow_trap_en :
      trap_en_i.acc_a_overflow_trap_en) |=> arith_trap_o;
  endproperty
  a_guard_trap: assert property (p_guard_trap)
    else $error("guard overflow trap missing");

  property p_q31_noguard;
    dsp_take && sat_en && !super_mode && !req_i.acc_sel
      |=> !status_o.acc_a_guard_overflow;
  endproperty
  a_q31_noguard: assert property (p_q31_noguard)
    else $error("guard flag set in bit 31 mode");

  property p_super_sat;
    dsp_take && sat_en && super_mode && ov39 && !req_i.acc_sel
      |=> (acc_a_o == DME_SUP_POS || acc_a_o == DME_SUP_NEG)
      && status_o.acc_a_saturated;
  endproperty
  a_super_sat: assert property (p_super_sat)
    else $error("super saturation value wrong");

  property p_cat_trap;
    dsp_take && !sat_en && ov39 && trap_en_i.catastrophic_trap_en
      && !req_i.acc_sel |=> arith_trap_o && (acc_a_o == $past(sum));
  endproperty
  a_cat_trap: assert property (p_cat_trap)
    else $error("catastrophic overflow trap missing");

  property p_mul_word;
    take && req_i.op == DME_OP_MUL && !req_i.mul_byte
      |=> mul_wr_o.valid && mul_wr_o.word;
  endproperty
  a_mul_word: assert property (p_mul_word)
    else $error("word multiply result not written");
endmodule
`default_nettype wire

// File: hw/dme_pkg.sv
// Shared types and constants of the DSP arithmetic engine
`default_nettype none
package dme_pkg;
  // Datapath widths and divider timing
  localparam int DME_ACC_W = 40;
  localparam int DME_DIV_CYCLES = 16;
  localparam logic [4:0] DME_DIV_CNT = 5'(DME_DIV_CYCLES);
  // Core control register field positions
  localparam int DME_CC_FRAC = 0;
  localparam int DME_CC_RND = 1;
  localparam int DME_CC_SAT_MODE = 4;
  localparam int DME_CC_DATASPACE_WRITE_SAT_ENABLE = 5;
  localparam int DME_CC_ACC_B_SAT_ENABLE = 6;
  localparam int DME_CC_ACC_A_SAT_ENABLE = 7;
  localparam int DME_CC_SIGN = 12;
  // Reset and saturation values
  localparam logic [39:0] DME_ACC_RST = 40'h00_0000_0000;
  localparam logic [39:0] DME_SUP_POS = 40'h07_ffff_ffff;
  localparam logic [39:0] DME_SUP_NEG = 40'h08_0000_0000;
  localparam logic [39:0] DME_Q31_POS = 40'h00_07ff_ffff;
  localparam logic [39:0] DME_Q31_NEG = 40'h00_8000_0000;

  typedef enum logic [3:0] {
    DME_OP_NONE = 4'h0,
    DME_OP_ADD_ACC = 4'h1,
    DME_OP_SUB_ACC = 4'h2,
    DME_OP_NEG_ACC = 4'h3,
    DME_OP_CLR = 4'h4,
    DME_OP_MAC = 4'h5,
    DME_OP_MSC = 4'h6,
    DME_OP_MPY = 4'h7,
    DME_OP_NEGATED_MULTIPLY_OP = 4'h8,
    DME_OP_ED = 4'h9,
    DME_OP_DIFF_SQUARE_ACCUM_OP = 4'ha,
    DME_OP_LAC = 4'hb,
    DME_OP_ADD_DATA = 4'hc,
    DME_OP_MUL = 4'hd,
    DME_OP_DIV = 4'he
  } dme_op_t;

  typedef enum logic {
    DME_IDLE = 1'b0,
    DME_DIV = 1'b1
  } dme_state_t;

  typedef struct packed {
    logic valid;
    dme_op_t op;
    logic acc_sel;
    logic div_signed;
    logic div_long;
    logic [3:0] divisor_idx;
    logic [3:0] dividend_idx;
    logic mul_byte;
    logic mul_x_signed;
    logic mul_y_signed;
  } dme_req_t;

  typedef struct packed {
    logic acc_a_overflow_trap_en;
    logic acc_b_overflow_trap_en;
    logic catastrophic_trap_en;
  } dme_trap_en_t;

  typedef struct packed {
    logic acc_a_guard_overflow;
    logic acc_b_guard_overflow;
    logic acc_a_saturated;
    logic acc_b_saturated;
    logic any_guard_overflow;
    logic any_saturated;
  } dme_status_t;

  typedef struct packed {
    logic valid;
    logic [15:0] quot;
    logic [15:0] rem;
  } dme_div_wr_t;

  typedef struct packed {
    logic valid;
    logic word;
    logic [31:0] data;
  } dme_mul_wr_t;
endpackage
`default_nettype wire

// File: tb/dme_engine_bench.sv
// Self-checking bench of the DSP arithmetic engine
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin err_total++; $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module dme_engine_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import dme_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  dme_req_t rq = '0;
  logic [15:0] x = '0;
  logic [15:0] y = '0;
  logic [39:0] sd = '0;
  logic [15:0] cc = '0;
  dme_trap_en_t ten = '0;
  logic [1:0] sclr = '0;
  logic ld_en = 1'b0;
  logic [3:0] ld_idx = '0;
  logic [15:0] ld_val = '0;
  logic [15:0][15:0] wf;
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  dme_status_t st;
  logic trap;
  logic busy;
  dme_div_wr_t dw;
  dme_mul_wr_t mw;
  int err_total = 0;
  int n_tests = 0;

  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  dme_engine uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(rq), .x_i(x),
    .y_i(y), .shift_data_i(sd), .wreg_file_i(wf), .core_control_reg_i(cc),
    .trap_en_i(ten), .sat_clear_i(sclr), .acc_a_o(acc_a), .acc_b_o(acc_b),
    .status_o(st), .arith_trap_o(trap), .busy_o(busy), .div_wr_o(dw),
    .mul_wr_o(mw));

  dme_wreg_model wregs (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .div_wr_i(dw),
    .ld_en_i(ld_en), .ld_idx_i(ld_idx), .ld_val_i(ld_val), .wreg_o(wf));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One request held across a single take edge
  task automatic dsp(input dme_op_t op, input logic sel, input logic [15:0] xa,
    input logic [15:0] ya, input logic [39:0] d, input logic byt);
    @(negedge ref_clk_i);
    rq = '0;
    rq.valid = 1'b1;
    rq.op = op;
    rq.acc_sel = sel;
    rq.mul_byte = byt;
    x = xa;
    y = ya;
    sd = d;
    @(negedge ref_clk_i);
    rq.valid = 1'b0;
  endtask

  task automatic wreg(input logic [3:0] idx, input logic [15:0] val);
    @(negedge ref_clk_i);
    ld_en = 1'b1;
    ld_idx = idx;
    ld_val = val;
    @(negedge ref_clk_i);
    ld_en = 1'b0;
  endtask

  // Divide, with a request thrown in while busy that must be ignored
  task automatic div(input logic sg, input logic lg, input logic [3:0] dv,
    input logic [3:0] dd, input logic [15:0] eq, input logic [15:0] er);
    int k;
    logic [39:0] b0;
    b0 = acc_b;
    @(negedge ref_clk_i);
    rq = '0;
    rq.valid = 1'b1;
    rq.op = DME_OP_DIV;
    rq.div_signed = sg;
    rq.div_long = lg;
    rq.divisor_idx = dv;
    rq.dividend_idx = dd;
    @(negedge ref_clk_i);
    rq.valid = 1'b0;
    k = 0;
    `CHK(busy, 1'b1)
    while (dw.valid !== 1'b1 && k < 40) begin
      if (k == 2) begin
        rq.op = DME_OP_MPY;
        rq.acc_sel = 1'b1;
        x = 16'h0005;
        y = 16'h0005;
        rq.valid = 1'b1;
      end
      if (k == 3) begin
        rq.valid = 1'b0;
      end
      @(negedge ref_clk_i);
      k++;
    end
    if (k >= 40) begin
      err_total++;
      tally_and_finish();
    end
    `CHK(k, 17)
    `CHK(dw.quot, eq)
    `CHK(dw.rem, er)
    `CHK(busy, 1'b0)
    `CHK(acc_b, b0)
    @(negedge ref_clk_i);
    `CHK(wf[0], eq)
    `CHK(wf[1], er)
  endtask

  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    `CHK(acc_a, DME_ACC_RST)
    `CHK(busy, 1'b0)
    `CHK(st, 6'h00)
    // Integer, fractional and unsigned products
    dsp(DME_OP_MPY, 1'b0, 16'h0003, 16'hfffe, '0, 1'b0);
    `CHK(acc_a, 40'hff_ffff_fffa)
    cc = 16'h0001;
    dsp(DME_OP_MPY, 1'b1, 16'h4000, 16'h4000, '0, 1'b0);
    `CHK(acc_b, 40'h00_2000_0000)
    cc = 16'h1000;
    dsp(DME_OP_MPY, 1'b0, 16'hffff, 16'h0002, '0, 1'b0);
    `CHK(acc_a, 40'h00_0001_fffe)
    cc = 16'h0000;
    // Accumulator to accumulator operations, then squared differences
    dsp(DME_OP_ADD_ACC, 1'b0, '0, '0, '0, 1'b0);
    `CHK(acc_a, 40'h00_2001_fffe)
    dsp(DME_OP_SUB_ACC, 1'b1, '0, '0, '0, 1'b0);
    `CHK(acc_b, 40'hff_fffe_0002)
    dsp(DME_OP_NEG_ACC, 1'b1, '0, '0, '0, 1'b0);
    `CHK(acc_b, 40'h00_0001_fffe)
    dsp(DME_OP_ED, 1'b0, 16'h0007, 16'h0004, '0, 1'b0);
    `CHK(acc_a, 40'h00_0000_0009)
    dsp(DME_OP_DIFF_SQUARE_ACCUM_OP, 1'b0, 16'h0002, 16'h0005, '0, 1'b0);
    `CHK(acc_a, 40'h00_0000_0012)
    // Integer multiplies write registers, not accumulators
    dsp(DME_OP_MUL, 1'b0, 16'h1234, 16'h0010, '0, 1'b0);
    `CHK(mw.valid, 1'b1)
    `CHK(mw.word, 1'b1)
    `CHK(mw.data, 32'h0001_2340)
    `CHK(acc_a, 40'h00_0000_0012)
    dsp(DME_OP_MUL, 1'b0, 16'h0012, 16'h0010, '0, 1'b1);
    `CHK(mw.word, 1'b0)
    `CHK(mw.data[15:0], 16'h0120)
    // Remaining product forms and clear
    dsp(DME_OP_MAC, 1'b0, 16'h0003, 16'h0004, '0, 1'b0);
    `CHK(acc_a, 40'h00_0000_001e)
    dsp(DME_OP_MSC, 1'b0, 16'h0002, 16'h0005, '0, 1'b0);
    `CHK(acc_a, 40'h00_0000_0014)
    dsp(DME_OP_NEGATED_MULTIPLY_OP, 1'b1, 16'h0003, 16'h0003, '0, 1'b0);
    `CHK(acc_b, 40'hff_ffff_fff7)
    dsp(DME_OP_CLR, 1'b1, '0, '0, '0, 1'b0);
    `CHK(acc_b, DME_ACC_RST)
    // Odd dividend index still selects the aligned pair
    wreg(4'h2, 16'h0005);
    wreg(4'h3, 16'h0001);
    wreg(4'h5, 16'h0010);
    div(1'b0, 1'b1, 4'h5, 4'h3, 16'h1000, 16'h0005);
    wreg(4'h4, 16'hfff9);
    wreg(4'h9, 16'h0002);
    div(1'b1, 1'b0, 4'h9, 4'h4, 16'hfffd, 16'hffff);
    // Guard overflow and its trap
    ten.acc_a_overflow_trap_en = 1'b1;
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'h01_0000_0000, 1'b0);
    `CHK(st.acc_a_guard_overflow, 1'b1)
    `CHK(st.any_guard_overflow, 1'b1)
    `CHK(trap, 1'b1)
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'h00_0000_0001, 1'b0);
    `CHK(st.acc_a_guard_overflow, 1'b0)
    `CHK(trap, 1'b0)
    // No saturation: wrap, sticky flag, catastrophic trap
    ten = '0;
    ten.catastrophic_trap_en = 1'b1;
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'h7f_ffff_ffff, 1'b0);
    dsp(DME_OP_ADD_DATA, 1'b0, '0, '0, 40'h00_0000_0001, 1'b0);
    `CHK(acc_a, 40'h80_0000_0000)
    `CHK(st.acc_a_saturated, 1'b1)
    `CHK(trap, 1'b1)
    `CHK(st.any_saturated, 1'b1)
    ten = '0;
    dsp(DME_OP_LAC, 1'b0, '0, '0, '0, 1'b0);
    `CHK(st.acc_a_saturated, 1'b1)
    @(negedge ref_clk_i);
    sclr = 2'b01;
    @(negedge ref_clk_i);
    sclr = 2'b00;
    `CHK(st.acc_a_saturated, 1'b0)
    // Super saturation, both signs
    cc = 16'h0090;
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'h7f_ffff_ffff, 1'b0);
    dsp(DME_OP_ADD_DATA, 1'b0, '0, '0, 40'h00_0000_0001, 1'b0);
    `CHK(acc_a, DME_SUP_POS)
    `CHK(st.acc_a_saturated, 1'b1)
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'h80_0000_0000, 1'b0);
    dsp(DME_OP_ADD_DATA, 1'b0, '0, '0, 40'hff_ffff_ffff, 1'b0);
    `CHK(acc_a, DME_SUP_NEG)
    // Bit 31 saturation; B has its enable off
    cc = 16'h0080;
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'h00_7fff_ffff, 1'b0);
    dsp(DME_OP_ADD_DATA, 1'b0, '0, '0, 40'h00_0000_0001, 1'b0);
    `CHK(acc_a, DME_Q31_POS)
    `CHK(st.acc_a_guard_overflow, 1'b0)
    dsp(DME_OP_LAC, 1'b0, '0, '0, 40'hff_8000_0000, 1'b0);
    dsp(DME_OP_ADD_DATA, 1'b0, '0, '0, 40'hff_ffff_ffff, 1'b0);
    `CHK(acc_a, DME_Q31_NEG)
    dsp(DME_OP_LAC, 1'b1, '0, '0, 40'h00_7fff_ffff, 1'b0);
    dsp(DME_OP_ADD_DATA, 1'b1, '0, '0, 40'h00_0000_0001, 1'b0);
    `CHK(acc_b, 40'h00_8000_0000)
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: tb/dme_wreg_model.sv
// Working register array model on the sequencer side of the engine
`default_nettype none
module dme_wreg_model
  import dme_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Divider write-back
  input wire dme_div_wr_t div_wr_i,
  // Bench preload port
  input wire logic ld_en_i,
  input wire logic [3:0] ld_idx_i,
  input wire logic [15:0] ld_val_i,
  // Register contents to the engine
  output logic [15:0][15:0] wreg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Write-back lands after preload so a result is never lost
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wreg_o <= '0;
    end else begin
      if (ld_en_i) begin
        wreg_o[ld_idx_i] <= ld_val_i;
      end
      if (div_wr_i.valid) begin
        wreg_o[0] <= div_wr_i.quot;
        wreg_o[1] <= div_wr_i.rem;
      end
    end
  end
endmodule
`default_nettype wire
